/* src/olv_regs.sv */
`timescale 1ns/1ps
module olv_regs #(
	parameter logic        RETRY_NVM  = 1'h0,
	parameter int unsigned DLY3_CYC   = olv_pkg::DLY3_CYC,
	parameter int unsigned HICCUP_CYC = olv_pkg::HICCUP_CYC
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_b_i,
	input  wire logic [7:0]               cmd_code_i,
	input  wire logic                     cmd_wr_i,
	input  wire logic                     cmd_rd_i,
	input  wire logic [15:0]              cmd_wdata_i,
	output logic      [15:0]              cmd_rdata_o,
	output logic                          cmd_ack_o,
	output logic                          cmd_nack_o,
	input  wire logic                     uv_fault_pin_i,
	input  wire logic                     cur_limit_pin_i,
	input  wire logic                     en_pin_i,
	input  wire logic                     out_cmd_on_i,
	input  wire logic                     other_fault_i,
	input  wire logic [olv_pkg::AVG_W-1:0] avg_current_i,
	output logic                          status_cml_o,
	output logic                          status_ivd_o,
	output logic                          status_oc_fault_o,
	output logic                          status_iout_o,
	output logic                          status_overcurrent_undervolt_flag_o,
	output logic                          status_oc_warn_o,
	output logic                          oc_warn_o,
	output logic                          host_alert_line_o,
	output logic                          host_alert_line_oe_b_o,
	output logic                          conv_on_o,
	output logic                          latched_o,
	output logic                          hiccup_o
);
	localparam int unsigned MW = olv_pkg::WARN_MANT_W;

	olv_pkg::olv_top_t r_reg;
	olv_pkg::olv_top_t r_next;
	olv_tmr_if         tmr_bus ();
	logic [7:0]        resp_byte;
	logic [2:0]        wr_retry;
	logic              wr_bad;
	logic              wr_ok;
	logic              clr;

	olv_fault_timer #(
		.DLY3_CYC   (DLY3_CYC),
		.HICCUP_CYC (HICCUP_CYC)
	) u_timer (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.bus     (tmr_bus)
	);

	assign tmr_bus.uv_fault = r_reg.s2[0];
	assign tmr_bus.cur_limit = r_reg.s2[1];
	assign tmr_bus.en = r_reg.s2[2];
	assign tmr_bus.act = r_reg.act;
	assign tmr_bus.retry_auto = r_reg.rty_hi;
	assign tmr_bus.dly_code = r_reg.dly;
	assign tmr_bus.out_cmd_on = out_cmd_on_i;
	assign tmr_bus.other_fault = other_fault_i;

	always_comb begin
		resp_byte = 8'h00;
		resp_byte[olv_pkg::RESP_ZERO_BIT] = 1'b0;
		resp_byte[olv_pkg::RESP_ACT_BIT] = r_reg.act;
		resp_byte[olv_pkg::RESP_RTY_HI:olv_pkg::RESP_RTY_LO] = {3{r_reg.rty_hi}};
		resp_byte[olv_pkg::RESP_DLY_TOP] = 1'b0;
		resp_byte[1:0] = r_reg.dly;
		wr_retry = cmd_wdata_i[olv_pkg::RESP_RTY_HI:olv_pkg::RESP_RTY_LO];
		wr_bad = 1'b0;
		wr_ok = 1'b0;
		clr = 1'b0;

		r_next = r_reg;
		r_next.s1 = {en_pin_i, cur_limit_pin_i, uv_fault_pin_i};
		r_next.s2 = r_reg.s1;
		r_next.ack = 1'b0;
		r_next.nack = 1'b0;
		r_next.rdata = 16'h0000;

		if (cmd_wr_i) begin
			case (cmd_code_i)
				olv_pkg::CMD_CLEAR_FAULTS: begin
					wr_ok = 1'b1;
					clr = 1'b1;
				end
				olv_pkg::CMD_UV_RESPONSE: begin
					if (wr_retry == olv_pkg::RETRY_LATCH || wr_retry == olv_pkg::RETRY_AUTO) begin
						wr_ok = 1'b1;
						r_next.act = cmd_wdata_i[olv_pkg::RESP_ACT_BIT];
						r_next.rty_hi = cmd_wdata_i[olv_pkg::RESP_RTY_HI];
						r_next.dly = cmd_wdata_i[1:0];
					end else begin
						wr_bad = 1'b1;
					end
				end
				olv_pkg::CMD_LV_RESPONSE: begin
					wr_bad = 1'b1;
				end
				olv_pkg::CMD_WARN_LIMIT: begin
					if (cmd_wdata_i[15:MW] == '0) begin
						wr_ok = 1'b1;
						r_next.warn_mant = cmd_wdata_i[MW-1:0];
					end else begin
						wr_bad = 1'b1;
					end
				end
				default: r_next.nack = 1'b1;
			endcase
			r_next.ack = wr_ok;
			if (wr_bad) begin
				r_next.nack = 1'b1;
			end
		end else if (cmd_rd_i) begin
			case (cmd_code_i)
				olv_pkg::CMD_UV_RESPONSE,
				olv_pkg::CMD_LV_RESPONSE: begin
					r_next.rdata = {8'h00, resp_byte};
					r_next.ack = 1'b1;
				end
				olv_pkg::CMD_WARN_LIMIT: begin
					r_next.rdata = {{(16 - MW){1'b0}}, r_reg.warn_mant};
					r_next.ack = 1'b1;
				end
				default: r_next.nack = 1'b1;
			endcase
		end

		// Sticky flags: a set in the same cycle as a clear wins.
		r_next.warn_lvl = avg_current_i >= olv_pkg::AVG_W'(r_reg.warn_mant);
		r_next.cml = (r_reg.cml & ~clr) | wr_bad;
		r_next.ivd = (r_reg.ivd & ~clr) | wr_bad;
		r_next.oc_fault = (r_reg.oc_fault & ~clr) | tmr_bus.fault_event;
		r_next.iout_sum = (r_reg.iout_sum & ~clr) | tmr_bus.fault_event | r_reg.warn_lvl;
		r_next.overcurrent_undervolt_flag = (r_reg.overcurrent_undervolt_flag & ~clr) | tmr_bus.fault_event;
		r_next.warn_sticky = (r_reg.warn_sticky & ~clr) | r_reg.warn_lvl;
		r_next.alert_oe_b = ~(r_next.cml | r_next.oc_fault | r_next.overcurrent_undervolt_flag | r_next.warn_sticky);
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r_reg <= '0;
			r_reg.act <= olv_pkg::ACT_RESET;
			r_reg.rty_hi <= RETRY_NVM;
			r_reg.dly <= olv_pkg::DLY_RESET;
			r_reg.warn_mant <= olv_pkg::WARN_RESET;
			r_reg.alert_oe_b <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign cmd_rdata_o = r_reg.rdata;
	assign cmd_ack_o = r_reg.ack;
	assign cmd_nack_o = r_reg.nack;
	assign status_cml_o = r_reg.cml;
	assign status_ivd_o = r_reg.ivd;
	assign status_oc_fault_o = r_reg.oc_fault;
	assign status_iout_o = r_reg.iout_sum;
	assign status_overcurrent_undervolt_flag_o = r_reg.overcurrent_undervolt_flag;
	assign status_oc_warn_o = r_reg.warn_sticky;
	assign oc_warn_o = r_reg.warn_lvl;
	assign host_alert_line_o = r_reg.s2[2] & 1'b0;
	assign host_alert_line_oe_b_o = r_reg.alert_oe_b;
	assign conv_on_o = tmr_bus.conv_on;
	assign latched_o = tmr_bus.latched;
	assign hiccup_o = tmr_bus.hiccup;
endmodule

/* src/olv_pkg.sv */
package olv_pkg;

	// Command codes on the management port.
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_UV_RESPONSE  = 8'h45;
	localparam logic [7:0] CMD_LV_RESPONSE  = 8'h49;
	localparam logic [7:0] CMD_WARN_LIMIT   = 8'h4A;

	// Field positions of the fault response byte.
	localparam int unsigned RESP_ZERO_BIT = 7;
	localparam int unsigned RESP_ACT_BIT  = 6;
	localparam int unsigned RESP_RTY_HI   = 5;
	localparam int unsigned RESP_RTY_LO   = 3;
	localparam int unsigned RESP_DLY_TOP  = 2;

	localparam logic [2:0] RETRY_LATCH = 3'h0;
	localparam logic [2:0] RETRY_AUTO  = 3'h7;

	// Reset values.
	localparam logic       ACT_RESET   = 1'h1;
	localparam logic [1:0] DLY_RESET   = 2'h0;
	localparam logic [5:0] WARN_RESET  = 6'h00;

	// Warning threshold layout: writable mantissa in the low bits only.
	localparam int unsigned WARN_MANT_W = 6;
	localparam int unsigned AVG_W       = 8;

	// Timing at the 40 MHz core clock.
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned DLY0_US       = 2;
	localparam int unsigned DLY1_US       = 16;
	localparam int unsigned DLY2_US       = 64;
	localparam int unsigned DLY3_US       = 256;
	localparam int unsigned HICCUP_MS     = 52;
	localparam int unsigned DLY0_CYC   = (DLY0_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DLY1_CYC   = (DLY1_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DLY2_CYC   = (DLY2_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DLY3_CYC   = (DLY3_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HICCUP_CYC = (HICCUP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W      = 22;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_DELAY,
		ST_LATCH,
		ST_HICCUP
	} olv_state_t;

	typedef struct packed {
		olv_state_t        state;
		logic [CNT_W-1:0]  cnt;
		logic              det_prev;
		logic              event_p;
		logic              conv_on;
		logic              latched;
		logic              hiccup;
	} olv_tmr_t;

	typedef struct packed {
		logic [2:0]             s1;
		logic [2:0]             s2;
		logic                   act;
		logic                   rty_hi;
		logic [1:0]             dly;
		logic [WARN_MANT_W-1:0] warn_mant;
		logic [15:0]            rdata;
		logic                   ack;
		logic                   nack;
		logic                   cml;
		logic                   ivd;
		logic                   oc_fault;
		logic                   iout_sum;
		logic                   overcurrent_undervolt_flag;
		logic                   warn_sticky;
		logic                   warn_lvl;
		logic                   alert_oe_b;
	} olv_top_t;

endpackage

/* src/olv_tmr_if.sv */
`timescale 1ns/1ps
interface olv_tmr_if;
	logic       uv_fault;
	logic       cur_limit;
	logic       en;
	logic       act;
	logic       retry_auto;
	logic [1:0] dly_code;
	logic       out_cmd_on;
	logic       other_fault;
	logic       fault_event;
	logic       conv_on;
	logic       latched;
	logic       hiccup;

	modport ctrl (
		output uv_fault, cur_limit, en, act, retry_auto, dly_code, out_cmd_on, other_fault,
		input  fault_event, conv_on, latched, hiccup
	);
	modport tmr (
		input  uv_fault, cur_limit, en, act, retry_auto, dly_code, out_cmd_on, other_fault,
		output fault_event, conv_on, latched, hiccup
	);
endinterface

/* src/olv_fault_timer.sv */
`timescale 1ns/1ps
module olv_fault_timer #(
	parameter int unsigned DLY3_CYC   = olv_pkg::DLY3_CYC,
	parameter int unsigned HICCUP_CYC = olv_pkg::HICCUP_CYC
) (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	olv_tmr_if.tmr    bus
);
	localparam int unsigned CW = olv_pkg::CNT_W;

	if (HICCUP_CYC < 1 || HICCUP_CYC >= (1 << CW) || DLY3_CYC < 1 || DLY3_CYC >= (1 << CW)) begin
		$error("olv_fault_timer: count parameter out of range");
	end

	olv_pkg::olv_tmr_t r_reg;
	olv_pkg::olv_tmr_t r_next;
	logic              det;
	logic [CW-1:0]     dly_load;

	always_comb begin
		det = bus.uv_fault & bus.cur_limit;
		case (bus.dly_code)
			2'h0: dly_load = CW'(olv_pkg::DLY0_CYC - 1);
			2'h1: dly_load = CW'(olv_pkg::DLY1_CYC - 1);
			2'h2: dly_load = CW'(olv_pkg::DLY2_CYC - 1);
			default: dly_load = CW'(DLY3_CYC - 1);
		endcase
		r_next = r_reg;
		r_next.det_prev = det;
		r_next.event_p = det & ~r_reg.det_prev;
		case (r_reg.state)
			olv_pkg::ST_RUN: begin
				if (det && bus.act) begin
					r_next.state = olv_pkg::ST_DELAY;
					r_next.cnt = dly_load;
				end
			end
			olv_pkg::ST_DELAY: begin
				if (!det) begin
					r_next.cnt = '0;
					r_next.state = olv_pkg::ST_RUN;
				end else if (r_reg.cnt == '0) begin
					if (bus.retry_auto) begin
						r_next.state = olv_pkg::ST_HICCUP;
						r_next.cnt = CW'(HICCUP_CYC - 1);
					end else begin
						r_next.state = olv_pkg::ST_LATCH;
					end
				end else begin
					r_next.cnt = r_reg.cnt - CW'(1);
				end
			end
			olv_pkg::ST_LATCH: begin
				// Only a low phase of the enable input releases the latch.
				if (!bus.en) begin
					r_next.state = olv_pkg::ST_RUN;
				end
			end
			olv_pkg::ST_HICCUP: begin
				if (bus.other_fault) begin
					r_next.state = olv_pkg::ST_LATCH;
				end else if (!bus.out_cmd_on || !bus.en) begin
					r_next.state = olv_pkg::ST_RUN;
					r_next.cnt = '0;
				end else if (r_reg.cnt == '0) begin
					r_next.state = olv_pkg::ST_RUN;
				end else begin
					r_next.cnt = r_reg.cnt - CW'(1);
				end
			end
			default: r_next.state = olv_pkg::ST_RUN;
		endcase
		r_next.conv_on = (r_next.state == olv_pkg::ST_RUN || r_next.state == olv_pkg::ST_DELAY)
			&& bus.en && bus.out_cmd_on;
		r_next.latched = r_next.state == olv_pkg::ST_LATCH;
		r_next.hiccup = r_next.state == olv_pkg::ST_HICCUP;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r_reg <= '{state: olv_pkg::ST_RUN, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign bus.fault_event = r_reg.event_p;
	assign bus.conv_on = r_reg.conv_on;
	assign bus.latched = r_reg.latched;
	assign bus.hiccup = r_reg.hiccup;
endmodule

/* tb/olv_regs_props.sv */
`timescale 1ns/1ps
module olv_regs_props (
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	input wire logic [7:0]  cmd_code_i,
	input wire logic        cmd_wr_i,
	input wire logic        cmd_rd_i,
	input wire logic [15:0] cmd_wdata_i,
	input wire logic [15:0] cmd_rdata_o,
	input wire logic        cmd_ack_o,
	input wire logic        cmd_nack_o,
	input wire logic        status_cml_o,
	input wire logic        status_ivd_o,
	input wire logic        status_oc_fault_o,
	input wire logic        status_iout_o,
	input wire logic        status_overcurrent_undervolt_flag_o,
	input wire logic        host_alert_line_oe_b_o,
	input wire logic        conv_on_o,
	input wire logic        latched_o,
	input wire logic        hiccup_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	rd_top_zero_a: assert property (cmd_rd_i && cmd_code_i == 8'h49 |=> cmd_rdata_o[15:7] == 9'h000)
		else $error("response read top bits not zero");
	dly_top_zero_a: assert property (cmd_rd_i && cmd_code_i == 8'h49 |=> !cmd_rdata_o[2])
		else $error("delay field top bit not zero");
	ro_write_a: assert property (cmd_wr_i && cmd_code_i == 8'h49 |=> cmd_nack_o && !cmd_ack_o)
		else $error("write to read-only response accepted");
	bad_retry_a: assert property (cmd_wr_i && cmd_code_i == 8'h45 &&
		!(cmd_wdata_i[5:3] inside {3'h0, 3'h7}) |=> cmd_nack_o ##[0:1] (status_ivd_o && status_cml_o))
		else $error("mixed retry code not refused");
	warn_ro_a: assert property (cmd_wr_i && cmd_code_i == 8'h4A && |cmd_wdata_i[15:6] |=> cmd_nack_o)
		else $error("warning threshold upper bits accepted");
	fault_flags_a: assert property ($rose(status_oc_fault_o) |-> status_overcurrent_undervolt_flag_o && status_iout_o)
		else $error("fault flags not set together");
	alert_pull_a: assert property (status_oc_fault_o || status_overcurrent_undervolt_flag_o |-> !host_alert_line_oe_b_o)
		else $error("alert not pulled on fault");
	latch_off_a: assert property (latched_o [*3] |-> !conv_on_o)
		else $error("conversion on while latched");
	hiccup_off_a: assert property (hiccup_o [*3] |-> !conv_on_o)
		else $error("conversion on during hiccup");
endmodule
bind olv_regs olv_regs_props u_props (.clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_code_i(cmd_code_i),
	.cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i), .cmd_wdata_i(cmd_wdata_i), .cmd_rdata_o(cmd_rdata_o),
	.cmd_ack_o(cmd_ack_o), .cmd_nack_o(cmd_nack_o), .status_cml_o(status_cml_o),
	.status_ivd_o(status_ivd_o), .status_oc_fault_o(status_oc_fault_o), .status_iout_o(status_iout_o),
	.status_overcurrent_undervolt_flag_o(status_overcurrent_undervolt_flag_o), .host_alert_line_oe_b_o(host_alert_line_oe_b_o),
	.conv_on_o(conv_on_o), .latched_o(latched_o), .hiccup_o(hiccup_o));

/* tb/olv_host.sv */
`timescale 1ns/1ps
module olv_host (
	input  wire logic        clk_i,
	output logic      [7:0]  code_o,
	output logic             wr_o,
	output logic             rd_o,
	output logic      [15:0] wdata_o,
	input  wire logic [15:0] rdata_i,
	input  wire logic        ack_i,
	input  wire logic        nack_i
);
	initial begin
		{code_o, wr_o, rd_o, wdata_o} = 26'h0;
	end
	task automatic xfer(input logic [7:0] c, input logic w, input logic [15:0] d,
		output logic a, output logic n, output logic [15:0] q);
		@(posedge clk_i);
		code_o <= c;
		wr_o <= w;
		rd_o <= !w;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'h0;
		rd_o <= 1'h0;
		// Released lines show inverted values so stale data cannot pass as valid.
		code_o <= ~c;
		wdata_o <= ~d;
		#1;
		a = ack_i;
		n = nack_i;
		q = rdata_i;
	endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [7:0]  c;
		logic        w;
		logic [15:0] d;
		logic        ak;
		logic [15:0] q;
	} olv_row_t;
	localparam olv_row_t ROWS [10] = '{
		'{8'h49, 1'h0, 16'h0000, 1'h1, 16'h0040}, '{8'h45, 1'h1, 16'h00BF, 1'h1, 16'h0000},
		'{8'h49, 1'h0, 16'h0000, 1'h1, 16'h003B}, '{8'h45, 1'h1, 16'h0010, 1'h0, 16'h0000},
		'{8'h49, 1'h0, 16'h0000, 1'h1, 16'h003B}, '{8'h49, 1'h1, 16'h0000, 1'h0, 16'h0000},
		'{8'h4A, 1'h1, 16'h0040, 1'h0, 16'h0000}, '{8'h4A, 1'h1, 16'h0014, 1'h1, 16'h0000},
		'{8'h4A, 1'h0, 16'h0000, 1'h1, 16'h0014}, '{8'h77, 1'h0, 16'h0000, 1'h0, 16'h0000}};
	logic        clk_i, rst_b_i, wr, rd, ack, nack, uv, cl, en, a, n;
	logic        cml, ivd, ocf, iout, overcurrent_undervolt_flag, warn_st, warn, alert, alert_oe_b, conv, latched, hiccup;
	logic        ocmd, ofl;
	logic [7:0]  code, avg;
	logic [15:0] wdata, rdata, q;
	int          fails = 0;
	int          cmp_count = 0;
	olv_host u_host (.clk_i(clk_i), .code_o(code), .wr_o(wr), .rd_o(rd), .wdata_o(wdata),
		.rdata_i(rdata), .ack_i(ack), .nack_i(nack));
	olv_regs #(.RETRY_NVM(1'h0), .DLY3_CYC(20), .HICCUP_CYC(50)) DUT (.clk_i(clk_i),
		.rst_b_i(rst_b_i), .cmd_code_i(code), .cmd_wr_i(wr), .cmd_rd_i(rd), .cmd_wdata_i(wdata),
		.cmd_rdata_o(rdata), .cmd_ack_o(ack), .cmd_nack_o(nack), .uv_fault_pin_i(uv),
		.cur_limit_pin_i(cl), .en_pin_i(en), .out_cmd_on_i(ocmd), .other_fault_i(ofl),
		.avg_current_i(avg), .status_cml_o(cml), .status_ivd_o(ivd), .status_oc_fault_o(ocf),
		.status_iout_o(iout), .status_overcurrent_undervolt_flag_o(overcurrent_undervolt_flag), .status_oc_warn_o(warn_st), .oc_warn_o(warn),
		.host_alert_line_o(alert), .host_alert_line_oe_b_o(alert_oe_b), .conv_on_o(conv),
		.latched_o(latched), .hiccup_o(hiccup));
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic summarize;
		$display("Checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic wreg(input logic [7:0] c, input logic [15:0] d);
		u_host.xfer(c, 1'h1, d, a, n, q);
	endtask
	task automatic flt(input logic v, input int k);
		@(posedge clk_i);
		uv <= v;
		cl <= v;
		repeat (k) @(posedge clk_i);
		#1;
	endtask
	task automatic tgl_en;
		@(posedge clk_i);
		en <= 1'h0;
		repeat (10) @(posedge clk_i);
		en <= 1'h1;
		repeat (10) @(posedge clk_i);
		#1;
	endtask
	initial begin
		clk_i = 1'h0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		fails++;
		summarize();
	end
	initial begin
		{rst_b_i, uv, cl} = 3'h0;
		en = 1'h1;
		ocmd = 1'h1;
		ofl = 1'h0;
		avg = 8'h00;
		repeat (20) @(posedge clk_i);
		chk("reset_state", {14'h0, alert_oe_b, conv}, 16'h0002);
		rst_b_i <= 1'h1;
		repeat (5) @(posedge clk_i);
		foreach (ROWS[i]) begin
			u_host.xfer(ROWS[i].c, ROWS[i].w, ROWS[i].d, a, n, q);
			chk("ack_nack", {14'h0, a, n}, {14'h0, ROWS[i].ak, !ROWS[i].ak});
			if (!ROWS[i].w) chk("rdata", q, ROWS[i].q);
		end
		chk("cml_ivd", {14'h0, cml, ivd}, 16'h0003);
		wreg(8'h03, 16'h0000);
		chk("cml_clear", {14'h0, cml, ivd}, 16'h0000);
		flt(1'h1, 40);
		chk("ignored", {10'h0, ocf, overcurrent_undervolt_flag, iout, conv, latched, hiccup}, 16'h003C);
		chk("alert", {14'h0, alert, alert_oe_b}, 16'h0000);
		flt(1'h0, 5);
		wreg(8'h45, 16'h0040);
		flt(1'h1, 60);
		chk("delay_run", {13'h0, conv, latched, hiccup}, 16'h0004);
		flt(1'h1, 40);
		chk("latch", {13'h0, conv, latched, hiccup}, 16'h0002);
		flt(1'h0, 10);
		chk("latch_hold", {13'h0, conv, latched, hiccup}, 16'h0002);
		tgl_en();
		chk("en_toggle", {13'h0, conv, latched, hiccup}, 16'h0004);
		wreg(8'h45, 16'h0043);
		flt(1'h1, 12);
		flt(1'h0, 30);
		chk("short_fault", {13'h0, conv, latched, hiccup}, 16'h0004);
		wreg(8'h45, 16'h007B);
		flt(1'h1, 30);
		chk("hiccup", {13'h0, conv, latched, hiccup}, 16'h0001);
		flt(1'h0, 60);
		chk("restart", {13'h0, conv, latched, hiccup}, 16'h0004);
		flt(1'h1, 30);
		@(posedge clk_i);
		ofl <= 1'h1;
		repeat (3) @(posedge clk_i);
		#1;
		chk("hiccup_fault", {13'h0, conv, latched, hiccup}, 16'h0002);
		@(posedge clk_i);
		ofl <= 1'h0;
		flt(1'h0, 10);
		tgl_en();
		flt(1'h1, 30);
		@(posedge clk_i);
		ocmd <= 1'h0;
		repeat (3) @(posedge clk_i);
		#1;
		chk("hiccup_stop", {13'h0, conv, latched, hiccup}, 16'h0000);
		@(posedge clk_i);
		ocmd <= 1'h1;
		flt(1'h0, 10);
		chk("cmd_resume", {13'h0, conv, latched, hiccup}, 16'h0004);
		@(posedge clk_i);
		avg <= 8'h13;
		repeat (3) @(posedge clk_i);
		#1;
		chk("warn_below", {14'h0, warn, warn_st}, 16'h0000);
		@(posedge clk_i);
		avg <= 8'h14;
		repeat (3) @(posedge clk_i);
		#1;
		chk("warn_at", {14'h0, warn, warn_st}, 16'h0003);
		wreg(8'h45, 16'h0038);
		@(posedge clk_i);
		rst_b_i <= 1'h0;
		repeat (3) @(posedge clk_i);
		rst_b_i <= 1'h1;
		u_host.xfer(8'h49, 1'h0, 16'h0000, a, n, q);
		chk("reset_again", q, 16'h0040);
		summarize();
	end
endmodule
